// File: pcsees_pkg.sv
// package: register map, field positions and fixed values of the pcs eee status bank
package pcsees_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  // ==========================================================
  localparam logic [5:0] IDX_STATUS = 6'h01; // pcs_status_one
  localparam logic [5:0] IDX_DEVPKG = 6'h05; // pcs_devices_in_package
  localparam logic [5:0] IDX_SIG = 6'h08; // pcs_present_signature
  localparam logic [5:0] IDX_CAP = 6'h14; // energy_efficient_capability
  localparam logic [5:0] IDX_WAKE = 6'h16; // wake_error_counter
  localparam logic [5:0] IDX_IRQ_STAT = 6'h20; // interrupt status, write one to clear
  localparam logic [5:0] IDX_IRQ_MASK = 6'h21; // interrupt mask

  // ==========================================================
  // pcs_status_one fields
  // ==========================================================
  localparam int ST_TX_LATCH = 11; // tx lpi seen, latch high
  localparam int ST_RX_LATCH = 10; // rx lpi seen, latch high
  localparam int ST_TX_NOW = 9; // tx lpi live
  localparam int ST_RX_NOW = 8; // rx lpi live
  localparam int ST_LINK = 2; // rx link, latch low

  // ==========================================================
  // devices-in-package fields
  // ==========================================================
  localparam int DEV_AN = 7; // auto-negotiation present
  localparam int DEV_PCS = 3; // coding sublayer present
  localparam int DEV_PMA = 1; // medium attachment present
  localparam int DEV_C22 = 0; // basic register set present

  // ==========================================================
  // signature and capability
  // ==========================================================
  localparam logic [1:0] SIG_CODE = 2'h2; // sublayer_signature, bits 15:14
  localparam int SIG_LSB = 14; // position of the signature code
  localparam int CAP_1000 = 2; // gigabit eee capable
  localparam int CAP_100 = 1; // 100 mb/s eee capable

  // ==========================================================
  // latch slots and interrupt bits
  // ==========================================================
  localparam int LAT_RX = 0; // rx lpi latch slot
  localparam int LAT_TX = 1; // tx lpi latch slot
  localparam int LAT_LINK = 2; // link latch slot
  localparam int LAT_N = 3; // number of latch slots
  localparam logic [LAT_N-1:0] LAT_LOW = 3'h4; // slots that latch low
  localparam int IRQ_RX = 0; // rx lpi entered
  localparam int IRQ_TX = 1; // tx lpi entered
  localparam int IRQ_LINK = 2; // link lost
  localparam int IRQ_WAKE = 3; // wake fault counted
  localparam int IRQ_W = 4; // interrupt bits
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0; // all masked after reset
  localparam logic [15:0] WAKE_RST = 16'h0000; // counter reset value

  // register select produced by the address decoder
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_STATUS = 3'b001,
    SEL_DEVPKG = 3'b010,
    SEL_SIG = 3'b011,
    SEL_CAP = 3'b100,
    SEL_WAKE = 3'b101,
    SEL_ISTAT = 3'b110,
    SEL_IMASK = 3'b111
  } pcsees_sel_t;

endpackage : pcsees_pkg

// File: pcsees_latch.sv
// module: one latch-high or latch-low status flag with clear on read
`timescale 1ns/100ps
module pcsees_latch #(
  parameter bit LOW = 1'b0, // 1 = latch low, 0 = latch high
  parameter bit RST_VAL = 1'b0 // value after reset
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic live, // present state of the watched condition
  input wire logic clr, // register read takes the flag back
  output logic q // latched flag
);

  // ==========================================================
  // latch
  // ==========================================================
  // on a read the flag reloads from the live value, so an event in
  // the read cycle itself survives the clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= RST_VAL;
    end else if (clr) begin
      q <= live;
    end else if (LOW) begin
      q <= q & live; // any drop sticks until read
    end else begin
      q <= q | live; // any rise sticks until read
    end
  end

endmodule : pcsees_latch

// File: pcsees_status_regs.sv
// module: pcs eee status, capability and wake-error registers on an avalon-mm slave
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module pcsees_status_regs #(
  parameter int ADDR_W = 8, // byte address width
  parameter int CNT_W = 16, // wake-error counter width
  parameter bit AUTONEG_PRESENT = 1'b1 // auto-negotiation built into the package
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  input wire logic rx_lpi_now,
  input wire logic tx_lpi_now,
  input wire logic rx_link_ok,
  input wire logic wake_fault
);

  // ==========================================================
  // declarations
  // ==========================================================
  localparam int LAT_LIVE_W = pcsees_pkg::LAT_N; // latch vector width
  localparam logic [CNT_W-1:0] CNT_MAX = '1; // saturation value
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1); // increment
  logic waitrequest_reg; // high except in the answer cycle
  logic [31:0] readdata_reg; // captured read word
  logic [31:0] readdata_next; // word chosen by the decoder
  logic irq_reg; // registered interrupt line
  logic accept; // request taken this edge
  logic done; // answer cycle, master samples now
  pcsees_pkg::pcsees_sel_t sel; // decoded register
  logic clr_status; // read of pcs_status_one
  logic clr_wake; // read of wake_error_counter
  logic [LAT_LIVE_W-1:0] lat_live; // live inputs of the latches
  logic [pcsees_pkg::LAT_N-1:0] lat_q; // latched status flags
  logic [CNT_W-1:0] wake_cnt_reg; // wake-error count
  logic [CNT_W-1:0] wake_cnt_next; // next count
  logic [pcsees_pkg::IRQ_W-1:0] istat_reg; // sticky interrupt bits
  logic [pcsees_pkg::IRQ_W-1:0] istat_next; // next sticky bits
  logic [pcsees_pkg::IRQ_W-1:0] imask_reg; // interrupt enables
  logic [pcsees_pkg::IRQ_W-1:0] ev; // interrupt events this cycle
  logic rx_lpi_prev_reg; // for edge of rx lpi
  logic tx_lpi_prev_reg; // for edge of tx lpi
  logic link_prev_reg; // for loss of link
  logic [15:0] w_low; // byte lane 0 of write data under its enable, bits 15:8 zero

  // ==========================================================
  // address decoder
  // ==========================================================
  // misaligned or unlisted addresses map to none and read as zero
  function automatic pcsees_pkg::pcsees_sel_t decode(input logic [ADDR_W-1:0] a);
    logic [5:0] idx;
    idx = a[7:2];
    if (a[1:0] != 2'h0) begin
      decode = pcsees_pkg::SEL_NONE;
    end else if (idx == pcsees_pkg::IDX_STATUS) begin
      decode = pcsees_pkg::SEL_STATUS;
    end else if (idx == pcsees_pkg::IDX_DEVPKG) begin
      decode = pcsees_pkg::SEL_DEVPKG;
    end else if (idx == pcsees_pkg::IDX_SIG) begin
      decode = pcsees_pkg::SEL_SIG;
    end else if (idx == pcsees_pkg::IDX_CAP) begin
      decode = pcsees_pkg::SEL_CAP;
    end else if (idx == pcsees_pkg::IDX_WAKE) begin
      decode = pcsees_pkg::SEL_WAKE;
    end else if (idx == pcsees_pkg::IDX_IRQ_STAT) begin
      decode = pcsees_pkg::SEL_ISTAT;
    end else if (idx == pcsees_pkg::IDX_IRQ_MASK) begin
      decode = pcsees_pkg::SEL_IMASK;
    end else begin
      decode = pcsees_pkg::SEL_NONE;
    end
  endfunction : decode

  // ==========================================================
  // bus handshake
  // ==========================================================
  // a request is taken while waitrequest is high; the next cycle is
  // the single answer cycle, so every access costs exactly two cycles
  assign accept = (read | write) & waitrequest_reg;
  assign done = (read | write) & ~waitrequest_reg;
  assign sel = decode(address);
  // read side effects fire together with the data capture, so a
  // flag or count that moves on that edge is never lost
  assign clr_status = accept & read & (sel == pcsees_pkg::SEL_STATUS);
  assign clr_wake = accept & read & (sel == pcsees_pkg::SEL_WAKE);

  // waitrequest drops for one cycle after each taken request
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      waitrequest_reg <= 1'b1;
    end else if (accept) begin
      waitrequest_reg <= 1'b0;
    end else begin
      waitrequest_reg <= 1'b1;
    end
  end

  // ==========================================================
  // read mux
  // ==========================================================
  // all words are 16 bits wide; upper half and reserved bits stay zero
  always_comb begin
    readdata_next = 32'h0000_0000;
    unique case (sel)
      pcsees_pkg::SEL_STATUS: begin
        readdata_next[pcsees_pkg::ST_TX_LATCH] = lat_q[pcsees_pkg::LAT_TX];
        readdata_next[pcsees_pkg::ST_RX_LATCH] = lat_q[pcsees_pkg::LAT_RX];
        readdata_next[pcsees_pkg::ST_TX_NOW] = tx_lpi_now;
        readdata_next[pcsees_pkg::ST_RX_NOW] = rx_lpi_now;
        readdata_next[pcsees_pkg::ST_LINK] = lat_q[pcsees_pkg::LAT_LINK];
      end
      pcsees_pkg::SEL_DEVPKG: begin
        readdata_next[pcsees_pkg::DEV_AN] = AUTONEG_PRESENT;
        readdata_next[pcsees_pkg::DEV_PCS] = 1'b1;
        readdata_next[pcsees_pkg::DEV_PMA] = 1'b1;
        readdata_next[pcsees_pkg::DEV_C22] = 1'b1;
      end
      pcsees_pkg::SEL_SIG: begin
        readdata_next[pcsees_pkg::SIG_LSB +: 2] = pcsees_pkg::SIG_CODE;
      end
      pcsees_pkg::SEL_CAP: begin
        readdata_next[pcsees_pkg::CAP_1000] = 1'b1;
        readdata_next[pcsees_pkg::CAP_100] = 1'b1;
      end
      pcsees_pkg::SEL_WAKE: begin
        readdata_next[CNT_W-1:0] = wake_cnt_reg;
      end
      pcsees_pkg::SEL_ISTAT: begin
        readdata_next[pcsees_pkg::IRQ_W-1:0] = istat_reg;
      end
      pcsees_pkg::SEL_IMASK: begin
        readdata_next[pcsees_pkg::IRQ_W-1:0] = imask_reg;
      end
      pcsees_pkg::SEL_NONE: begin
        readdata_next = 32'h0000_0000; // unmapped reads as zero
      end
    endcase
  end

  // read word captured at the accept edge, held through the answer
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      readdata_reg <= 32'h0000_0000;
    end else if (accept & read) begin
      readdata_reg <= readdata_next;
    end
  end

  // ==========================================================
  // latched status flags
  // ==========================================================
  assign lat_live[pcsees_pkg::LAT_RX] = rx_lpi_now;
  assign lat_live[pcsees_pkg::LAT_TX] = tx_lpi_now;
  assign lat_live[pcsees_pkg::LAT_LINK] = rx_link_ok;

  // one cell per flag, polarity taken from the latch-low mask
  generate
    for (genvar i = 0; i < pcsees_pkg::LAT_N; i++) begin : g_lat
      pcsees_latch #(
        .LOW(pcsees_pkg::LAT_LOW[i]),
        .RST_VAL(1'b0)
      ) u_lat (
        .mclk(mclk),
        .rstn(rstn),
        .live(lat_live[i]),
        .clr(clr_status),
        .q(lat_q[i])
      );
    end
  endgenerate

  // ==========================================================
  // wake-error counter
  // ==========================================================
  // a fault in the read cycle restarts the count at one
  always_comb begin
    if (clr_wake) begin
      wake_cnt_next = wake_fault ? CNT_ONE : '0;
    end else if (wake_fault && (wake_cnt_reg != CNT_MAX)) begin
      wake_cnt_next = wake_cnt_reg + CNT_ONE;
    end else begin
      wake_cnt_next = wake_cnt_reg; // holds at all ones
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wake_cnt_reg <= pcsees_pkg::WAKE_RST[CNT_W-1:0];
    end else begin
      wake_cnt_reg <= wake_cnt_next;
    end
  end

  // ==========================================================
  // interrupt events
  // ==========================================================
  // lpi and link use edges, not levels, so a long lpi period raises one event only; wake fault is a level
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rx_lpi_prev_reg <= 1'b0;
      tx_lpi_prev_reg <= 1'b0;
      link_prev_reg <= 1'b0;
    end else begin
      rx_lpi_prev_reg <= rx_lpi_now;
      tx_lpi_prev_reg <= tx_lpi_now;
      link_prev_reg <= rx_link_ok;
    end
  end

  assign ev[pcsees_pkg::IRQ_RX] = rx_lpi_now & ~rx_lpi_prev_reg;
  assign ev[pcsees_pkg::IRQ_TX] = tx_lpi_now & ~tx_lpi_prev_reg;
  assign ev[pcsees_pkg::IRQ_LINK] = link_prev_reg & ~rx_link_ok;
  assign ev[pcsees_pkg::IRQ_WAKE] = wake_fault;

  // byte lane 0 carries every writable bit
  assign w_low = {8'h00, byteenable[0] ? writedata[7:0] : 8'h00};

  // write one clears; a new event in the same cycle wins
  always_comb begin
    istat_next = istat_reg;
    if (done && write && (sel == pcsees_pkg::SEL_ISTAT)) begin
      istat_next = istat_reg & ~w_low[pcsees_pkg::IRQ_W-1:0];
    end
    istat_next = istat_next | ev;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      istat_reg <= '0;
    end else begin
      istat_reg <= istat_next;
    end
  end

  // mask is the only plainly stored register; interrupt status takes write-one-to-clear, writes elsewhere are dropped
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      imask_reg <= pcsees_pkg::IRQ_MASK_RST;
    end else if (done && write && (sel == pcsees_pkg::SEL_IMASK) && byteenable[0]) begin
      imask_reg <= writedata[pcsees_pkg::IRQ_W-1:0];
    end
  end

  // level interrupt, one cycle behind the sticky bits
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(istat_reg & imask_reg);
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign readdata = readdata_reg;
  assign waitrequest = waitrequest_reg;
  assign irq = irq_reg;

  // ==========================================================
  // assertions
  // ==========================================================
  logic rd_status_d; // status read taken last edge
  logic rd_dev_d; // package word read taken last edge
  logic rd_sig_d; // signature read taken last edge
  logic rd_cap_d; // capability read taken last edge
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rd_status_d <= 1'b0;
      rd_dev_d <= 1'b0;
      rd_sig_d <= 1'b0;
      rd_cap_d <= 1'b0;
    end else begin
      rd_status_d <= clr_status;
      rd_dev_d <= accept & read & (sel == pcsees_pkg::SEL_DEVPKG);
      rd_sig_d <= accept & read & (sel == pcsees_pkg::SEL_SIG);
      rd_cap_d <= accept & read & (sel == pcsees_pkg::SEL_CAP);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_rx_latch;
    lat_q[pcsees_pkg::LAT_RX] && !clr_status |=> lat_q[pcsees_pkg::LAT_RX];
  endproperty
  a_rx_latch: assert property (p_rx_latch) else $error("rx lpi latch dropped without read");

  property p_tx_latch;
    tx_lpi_now |=> lat_q[pcsees_pkg::LAT_TX];
  endproperty
  a_tx_latch: assert property (p_tx_latch) else $error("tx lpi latch not set");

  property p_tx_live;
    clr_status |=> readdata_reg[pcsees_pkg::ST_TX_NOW] == $past(tx_lpi_now);
  endproperty
  a_tx_live: assert property (p_tx_live) else $error("bit 9 not live tx lpi");

  property p_rx_live;
    clr_status |=> readdata_reg[pcsees_pkg::ST_RX_NOW] == $past(rx_lpi_now);
  endproperty
  a_rx_live: assert property (p_rx_live) else $error("bit 8 not live rx lpi");

  property p_link_low;
    !rx_link_ok ##1 (rx_link_ok && !clr_status) |=> !lat_q[pcsees_pkg::LAT_LINK];
  endproperty
  a_link_low: assert property (p_link_low) else $error("link latch rose without read");

  property p_devpkg;
    rd_dev_d |-> readdata_reg[15:0] == {8'h00, AUTONEG_PRESENT, 7'h0B};
  endproperty
  a_devpkg: assert property (p_devpkg) else $error("package word wrong");

  property p_sig;
    rd_sig_d |-> readdata_reg == 32'h0000_8000;
  endproperty
  a_sig: assert property (p_sig) else $error("signature word wrong");

  property p_cap;
    rd_cap_d |-> readdata_reg == 32'h0000_0006;
  endproperty
  a_cap: assert property (p_cap) else $error("capability word wrong");

  property p_wake_clr;
    clr_wake && !wake_fault |=> wake_cnt_reg == '0;
  endproperty
  a_wake_clr: assert property (p_wake_clr) else $error("wake counter not cleared by read");

  property p_wake_sat;
    wake_cnt_reg == CNT_MAX && !clr_wake |=> wake_cnt_reg == CNT_MAX;
  endproperty
  a_wake_sat: assert property (p_wake_sat) else $error("wake counter wrapped");

  property p_reserved;
    rd_status_d |-> (readdata_reg & 32'hFFFF_F0FB) == 32'h0000_0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved status bits set");

  property p_answer;
    accept |=> !waitrequest ##1 waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("answer not one cycle");

  c_status: cover property (clr_status ##1 readdata_reg[pcsees_pkg::ST_RX_LATCH]);
  c_link: cover property (rd_status_d && !readdata_reg[pcsees_pkg::ST_LINK] && rx_link_ok);
  c_sat: cover property (wake_cnt_reg == CNT_MAX && wake_fault);
  c_irq: cover property (irq ##1 !irq);

endmodule : pcsees_status_regs

// File: pcs_eee_status_regs_tb_top.sv
// testbench: register reads and writes over avalon-mm against the pcs eee status bank
`timescale 1ns/100ps
// compare one value, count it, report a mismatch at once
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module pcs_eee_status_regs_tb_top;
  // ==========================================================
  // signals
  // ==========================================================
  logic mclk; // 25 mhz bench clock
  logic rstn; // active-low reset
  logic [7:0] address; // avalon byte address
  logic read; // avalon read
  logic write; // avalon write
  logic [31:0] writedata; // avalon write data
  logic [3:0] byteenable; // avalon byte lanes
  logic [31:0] readdata; // avalon read data
  logic waitrequest; // avalon stall
  logic irq; // level interrupt
  logic rx_lpi_now; // receive side in lpi
  logic tx_lpi_now; // transmit side in lpi
  logic rx_link_ok; // receive link up
  logic wake_fault; // wake-time fault pulse
  int n_mismatch; // mismatches seen
  int cmp_count; // comparisons made
  logic [31:0] d; // last read word
  // byte addresses, index times four
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_DEV = 8'h14;
  localparam logic [7:0] A_SIG = 8'h20;
  localparam logic [7:0] A_CAP = 8'h50;
  localparam logic [7:0] A_WAKE = 8'h58;
  localparam logic [7:0] A_ISTAT = 8'h80;
  localparam logic [7:0] A_IMASK = 8'h84;
  localparam logic [7:0] A_HOLE = 8'h0C; // unmapped word
  // ==========================================================
  // clock, design
  // ==========================================================
  // free-running clock, 40 ns period
  always #20 mclk = ~mclk;
  pcsees_status_regs DUT (
    .mclk(mclk),
    .rstn(rstn),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .byteenable(byteenable),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .irq(irq),
    .rx_lpi_now(rx_lpi_now),
    .tx_lpi_now(tx_lpi_now),
    .rx_link_ok(rx_link_ok),
    .wake_fault(wake_fault)
  );
  // ==========================================================
  // bus tasks
  // ==========================================================
  // hold the request until waitrequest is sampled low; taken at the first edge, answered at the second
  task automatic bus_xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge mclk);
    address <= a;
    read <= ~wr;
    write <= wr;
    writedata <= wd;
    byteenable <= be;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    d = readdata;
    `CHK("answer_cycles", 2, n)
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus_xfer
  // read one word and compare it
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    bus_xfer(a, 1'b0, 32'h00000000, 4'hF);
    `CHK(nm, exp, d)
  endtask : rd
  // write one word with all lanes on
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    bus_xfer(a, 1'b1, wd, 4'hF);
  endtask : wr
  // one-cycle event on the chosen link input: 0 rx lpi, 1 tx lpi, 2 link loss, 3 wake fault
  task automatic fire(input int i);
    @(posedge mclk);
    case (i)
      0: rx_lpi_now <= 1'b1;
      1: tx_lpi_now <= 1'b1;
      2: rx_link_ok <= 1'b0;
      default: wake_fault <= 1'b1;
    endcase
    @(posedge mclk);
    rx_lpi_now <= 1'b0;
    tx_lpi_now <= 1'b0;
    rx_link_ok <= 1'b1;
    wake_fault <= 1'b0;
  endtask : fire
  // let the irq lag and latches settle
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle
  // verdict and end of run
  task automatic wrap_up();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  // ==========================================================
  // tests
  // ==========================================================
  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
    byteenable = 4'h0;
    rx_lpi_now = 1'b0;
    tx_lpi_now = 1'b0;
    rx_link_ok = 1'b1;
    wake_fault = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    d = 32'h00000000;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    `CHK("irq_after_reset", 1'b0, irq)
    // fixed words, then writes at them must change nothing
    rd(A_DEV, 32'h0000008B, "devpkg");
    rd(A_SIG, 32'h00008000, "signature");
    rd(A_CAP, 32'h00000006, "capability");
    wr(A_DEV, 32'h0000FF74);
    wr(A_SIG, 32'h00007FFF);
    wr(A_CAP, 32'h0000FFF9);
    rd(A_DEV, 32'h0000008B, "devpkg_after_wr");
    rd(A_SIG, 32'h00008000, "signature_after_wr");
    rd(A_CAP, 32'h00000006, "capability_after_wr");
    rd(A_HOLE, 32'h00000000, "unmapped");
    rd(A_IMASK, 32'h00000000, "mask_reset");
    // link latch starts low, the read reloads it from the live link
    rd(A_STAT, 32'h00000000, "status_first");
    rd(A_STAT, 32'h00000004, "status_link_up");
    wr(A_STAT, 32'h0000FFFF);
    rd(A_STAT, 32'h00000004, "status_after_wr");
    // short lpi bursts are held until read, then gone
    fire(0);
    rd(A_STAT, 32'h00000404, "rx_lpi_latched");
    rd(A_STAT, 32'h00000004, "rx_lpi_cleared");
    fire(1);
    rd(A_STAT, 32'h00000804, "tx_lpi_latched");
    rd(A_STAT, 32'h00000004, "tx_lpi_cleared");
    // held lpi shows live; latch survives the read while the input is still up
    rx_lpi_now <= 1'b1;
    idle(2);
    rd(A_STAT, 32'h00000504, "rx_lpi_live");
    rx_lpi_now <= 1'b0;
    idle(2);
    rd(A_STAT, 32'h00000404, "rx_live_gone");
    rd(A_STAT, 32'h00000004, "rx_all_clear");
    tx_lpi_now <= 1'b1;
    idle(2);
    rd(A_STAT, 32'h00000A04, "tx_lpi_live");
    tx_lpi_now <= 1'b0;
    idle(2);
    rd(A_STAT, 32'h00000804, "tx_live_gone");
    rd(A_STAT, 32'h00000004, "tx_all_clear");
    // a single-cycle link drop must not be missed
    fire(2);
    rd(A_STAT, 32'h00000000, "link_lost");
    rd(A_STAT, 32'h00000004, "link_back");
    // interrupts: each event sticks, masked first, then enabled, then cleared
    wr(A_ISTAT, 32'h0000000F);
    bus_xfer(A_IMASK, 1'b1, 32'h0000000F, 4'h0);
    rd(A_IMASK, 32'h00000000, "mask_lane_off");
    for (int i = 0; i < 4; i++) begin
      fire(i);
      idle(3);
      rd(A_ISTAT, 32'h00000001 << i, "istat_set");
      `CHK("irq_masked", 1'b0, irq)
      wr(A_IMASK, 32'h00000001 << i);
      idle(3);
      `CHK("irq_enabled", 1'b1, irq)
      wr(A_ISTAT, 32'h00000001 << i);
      idle(3);
      `CHK("irq_cleared", 1'b0, irq)
      rd(A_ISTAT, 32'h00000000, "istat_cleared");
      wr(A_IMASK, 32'h00000000);
    end
    // wake faults: one per cycle, clear on read, stick at all ones
    rd(A_WAKE, 32'h00000001, "wake_from_irq_test");
    rd(A_WAKE, 32'h00000000, "wake_cleared");
    wake_fault <= 1'b1;
    idle(3);
    wake_fault <= 1'b0;
    rd(A_WAKE, 32'h00000003, "wake_count");
    rd(A_WAKE, 32'h00000000, "wake_read_clear");
    wake_fault <= 1'b1;
    idle(65540);
    wake_fault <= 1'b0;
    rd(A_WAKE, 32'h0000FFFF, "wake_saturated");
    rd(A_WAKE, 32'h00000000, "wake_after_sat");
    wrap_up();
  end
  // watchdog: the whole sequence needs well under 70000 cycles
  initial begin
    repeat (90000) @(posedge mclk);
    n_mismatch++;
    wrap_up();
  end
endmodule : pcs_eee_status_regs_tb_top
